//--- design/osc_ctrl_pkg.sv
// shared constants and carrier types for the system clock source controller
package osc_ctrl_pkg;

    // =========================================================
    // register addresses on the special-function-register bus
    localparam logic [7:0] INT_OSC_CTRL_ADDR = 8'h8a;
    localparam logic [7:0] EXT_OSC_CTRL_ADDR = 8'h8c;
    localparam logic [7:0] CLK_SRC_ADDR = 8'h8f;

    // =========================================================
    // field positions
    localparam int INT_EN_BIT = 7;     // internal oscillator enable
    localparam int INT_RDY_BIT = 6;    // internal oscillator ready, read only
    localparam int DIV_LSB = 0;        // two-bit divide select
    localparam int EXT_VALID_BIT = 7;  // crystal valid, read only
    localparam int EXT_MODE_LSB = 4;   // three-bit external mode
    localparam int EXT_FREQ_LSB = 0;   // three-bit frequency control
    localparam int CLK_SRC_BIT = 0;    // system clock source select

    // =========================================================
    // reset values
    localparam logic [7:0] INT_OSC_CTRL_RST = 8'hc0;
    localparam logic [7:0] EXT_OSC_CTRL_RST = 8'h00;
    localparam logic [7:0] CLK_SRC_RST = 8'h00;

    // =========================================================
    // external mode groups, upper two bits of the mode field
    localparam logic [1:0] EXT_GRP_OFF = 2'h0;
    localparam logic [1:0] EXT_GRP_CMOS = 2'h1;
    localparam logic [1:0] EXT_GRP_RC = 2'h2;
    localparam logic [1:0] EXT_GRP_XTAL = 2'h3;

    // =========================================================
    // internal divider terminal counts per divide select code
    localparam logic [2:0] TERM_DIV8 = 3'h7;
    localparam logic [2:0] TERM_DIV4 = 3'h3;
    localparam logic [2:0] TERM_DIV2 = 3'h1;
    localparam logic [2:0] TERM_DIV1 = 3'h0;

    // one bus request from the core
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrEn;
        logic rdEn;
    } sfr_req_s;

    // settings that steer the analog oscillators
    typedef struct packed {
        logic intOscEnable;
        logic [1:0] extGroup;
        logic extDivBy2;
        logic [2:0] extFreqSel;
    } osc_drive_s;

    // effective system clock source
    typedef enum logic {SRC_INTERNAL, SRC_EXTERNAL} src_e;

    // terminal count of the internal divider for a divide select code
    function automatic logic [2:0] divTerminal(input logic [1:0] sel);
        case (sel)
            2'h0: divTerminal = TERM_DIV8;
            2'h1: divTerminal = TERM_DIV4;
            2'h2: divTerminal = TERM_DIV2;
            default: divTerminal = TERM_DIV1;
        endcase
    endfunction

endpackage

//--- design/int_clk_divider.sv
// divider that thins internal oscillator ticks by one, two, four or eight
`timescale 1ns/1ps
module int_clk_divider #(
    parameter int MAX_DIV = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic oscTick,
    input wire logic [1:0] divideSel,
    output logic divTick
);
    import osc_ctrl_pkg::*;

    // =========================================================
    // elaboration check, refuses any largest ratio other than eight
    if (MAX_DIV != 8) begin : g_bad_ratio
        $error("int_clk_divider only serves a largest ratio of eight");
    end

    logic [2:0] count;                       // ticks seen in this period
    wire [2:0] terminal = divTerminal(divideSel);
    wire atTerminal = (count >= terminal);   // a shrinking ratio never strands the count
    wire [2:0] next_count = atTerminal ? 3'h0 : count + 3'h1;

    // count ticks only while the oscillator runs; a stopped one gives none
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 3'h0;
            divTick <= 1'b0;
        end else if (!enable) begin
            count <= 3'h0;
            divTick <= 1'b0;
        end else begin
            if (oscTick) begin
                count <= next_count;
            end
            divTick <= oscTick && atTerminal;
        end
    end

    // =========================================================
    // assertions
    a_div_stopped: assert property (@(posedge clk) disable iff (!rst_n)
        !enable |=> !divTick) else $error("divided tick while oscillator stopped");
    a_div_terminal: assert property (@(posedge clk) disable iff (!rst_n)
        divTick |-> $past(oscTick && enable && count >= divTerminal(divideSel)))
        else $error("divided tick away from the terminal count");
endmodule

//--- design/system_clock_select.sv
// system clock source controller: internal oscillator control, divider, source switch
`timescale 1ns/1ps
module system_clock_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire osc_ctrl_pkg::sfr_req_s sfrReq,
    output logic [7:0] sfrRdData,
    input wire logic intOscTick,
    input wire logic extOscTick,
    input wire logic intOscAtFreq,
    input wire logic extOscSettled,
    output osc_ctrl_pkg::osc_drive_s oscDrive,
    output logic sysClkTick,
    output logic periphExtTick,
    output logic sysclkIsExternal,
    output logic extOscReady
);
    import osc_ctrl_pkg::*;

    // =========================================================
    // registers
    logic intOscEnable;          // internal oscillator run bit
    logic [1:0] intClkDivideSel; // internal divide select
    logic [2:0] extMode;         // external oscillator mode
    logic [2:0] extOscFreqSel;   // external frequency control
    logic sysclkSourceBit;       // requested system clock source
    src_e srcState;              // source actually driving the system clock

    // =========================================================
    // synchronisers for levels from the analog oscillators
    logic intRdySync1;
    logic intRdySync2;
    logic extSetSync1;
    logic extSetSync2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intRdySync1 <= 1'b0;
            intRdySync2 <= 1'b0;
            extSetSync1 <= 1'b0;
            extSetSync2 <= 1'b0;
        end else begin
            intRdySync1 <= intOscAtFreq;
            intRdySync2 <= intRdySync1;
            extSetSync1 <= extOscSettled;
            extSetSync2 <= extSetSync1;
        end
    end

    // =========================================================
    // decode
    wire wrIntCtrl = sfrReq.wrEn && (sfrReq.addr == INT_OSC_CTRL_ADDR);
    wire wrExtCtrl = sfrReq.wrEn && (sfrReq.addr == EXT_OSC_CTRL_ADDR);
    wire wrClkSrc = sfrReq.wrEn && (sfrReq.addr == CLK_SRC_ADDR);
    wire [1:0] extGroup = extMode[2:1];
    wire extRunning = (extGroup != EXT_GRP_OFF);
    wire intOscFreqReady = intOscEnable && intRdySync2;
    wire crystalValidFlag = (extGroup == EXT_GRP_XTAL) && extSetSync2;
    // rc and cmos modes are usable at once; crystal waits for valid
    wire next_extOscReady = (extGroup == EXT_GRP_RC) || (extGroup == EXT_GRP_CMOS)
                          || crystalValidFlag;

    // register images as read back; reserved bits read zero
    wire [7:0] intCtrlImage = {intOscEnable, intOscFreqReady, 4'h0, intClkDivideSel};
    wire [7:0] extCtrlImage = {crystalValidFlag, extMode, 1'b0, extOscFreqSel};
    wire [7:0] clkSrcImage = {7'h00, sysclkSourceBit};
    wire [7:0] next_rdData = (sfrReq.addr == INT_OSC_CTRL_ADDR) ? intCtrlImage :
                             (sfrReq.addr == EXT_OSC_CTRL_ADDR) ? extCtrlImage :
                             (sfrReq.addr == CLK_SRC_ADDR) ? clkSrcImage : 8'h00;

    // =========================================================
    // register writes; one internal-control write may enable and divide together
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intOscEnable <= INT_OSC_CTRL_RST[INT_EN_BIT];
            intClkDivideSel <= INT_OSC_CTRL_RST[DIV_LSB +: 2];
            extMode <= EXT_OSC_CTRL_RST[EXT_MODE_LSB +: 3];
            extOscFreqSel <= EXT_OSC_CTRL_RST[EXT_FREQ_LSB +: 3];
            sysclkSourceBit <= CLK_SRC_RST[CLK_SRC_BIT];
        end else begin
            if (wrIntCtrl) begin
                intOscEnable <= sfrReq.wrData[INT_EN_BIT];
                intClkDivideSel <= sfrReq.wrData[DIV_LSB +: 2];
            end
            if (wrExtCtrl) begin
                extMode <= sfrReq.wrData[EXT_MODE_LSB +: 3];
                extOscFreqSel <= sfrReq.wrData[EXT_FREQ_LSB +: 3];
            end
            if (wrClkSrc) begin
                sysclkSourceBit <= sfrReq.wrData[CLK_SRC_BIT];
            end
        end
    end

    // read data is captured on a read strobe and held until the next
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sfrRdData <= 8'h00;
        end else if (sfrReq.rdEn) begin
            sfrRdData <= next_rdData;
        end
    end

    // =========================================================
    // source switch; follows the select bit one cycle later, reset loads internal
    src_e next_srcState;

    always_comb begin
        case (srcState)
            SRC_INTERNAL: next_srcState = sysclkSourceBit ? SRC_EXTERNAL : SRC_INTERNAL;
            SRC_EXTERNAL: next_srcState = sysclkSourceBit ? SRC_EXTERNAL : SRC_INTERNAL;
            default: next_srcState = SRC_INTERNAL;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            srcState <= SRC_INTERNAL;
        end else begin
            srcState <= next_srcState;
        end
    end

    // =========================================================
    // internal divider
    logic intDivTick; // divided internal oscillator tick

    int_clk_divider #(
        .MAX_DIV(8)
    ) u_divider (
        .clk(clk),
        .rst_n(rst_n),
        .enable(intOscEnable),
        .oscTick(intOscTick),
        .divideSel(intClkDivideSel),
        .divTick(intDivTick)
    );

    // =========================================================
    // clock outputs; peripherals keep the external tick whatever the source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sysClkTick <= 1'b0;
            periphExtTick <= 1'b0;
            sysclkIsExternal <= 1'b0;
            extOscReady <= 1'b0;
        end else begin
            sysClkTick <= (srcState == SRC_EXTERNAL) ? extOscTick : intDivTick;
            periphExtTick <= extRunning && extOscTick;
            sysclkIsExternal <= (srcState == SRC_EXTERNAL);
            extOscReady <= next_extOscReady;
        end
    end

    // one driver for the whole drive bundle
    assign oscDrive = '{
        intOscEnable: intOscEnable,
        extGroup: extGroup,
        extDivBy2: extMode[0],
        extFreqSel: extOscFreqSel
    };

    // helper: raw settled input high at this and the two previous samples
    logic extSettled3;
    logic [1:0] settledHist;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settledHist <= 2'h0;
        end else begin
            settledHist <= {settledHist[0], extOscSettled};
        end
    end
    assign extSettled3 = &settledHist && extOscSettled;

    // =========================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_select_ext;
        wrClkSrc && sfrReq.wrData[CLK_SRC_BIT];
    endsequence

    // state follows one cycle after the bit, the output one cycle after the state
    sequence s_ext_lands;
        ##1 (srcState == SRC_EXTERNAL) ##1 sysclkIsExternal;
    endsequence

    // divider and output register need three stopped samples to drain
    sequence s_int_stopped;
        (!intOscEnable) [*3];
    endsequence

    a_int_osc_off: assert property (s_int_stopped |-> !sysClkTick || sysclkIsExternal)
        else $error("internal path ticked while oscillator off");
    a_src_follow: assert property ((sysclkSourceBit == 1'b0) |=> ##1 !sysclkIsExternal)
        else $error("external source without select bit");
    a_sys_tick_ext: assert property ((srcState == SRC_EXTERNAL) && extOscTick |=> sysClkTick)
        else $error("external tick lost on system clock");
    a_periph_ext: assert property (extRunning && extOscTick |=> periphExtTick)
        else $error("peripheral external tick lost");
    a_switch_live: assert property (s_select_ext |=> s_ext_lands)
        else $error("source switch did not take effect");
    a_one_write: assert property (wrIntCtrl && sfrReq.wrData[INT_EN_BIT] && !sysclkSourceBit && !wrClkSrc
        |=> intOscEnable && srcState == SRC_INTERNAL)
        else $error("single write did not enable internal oscillator");
    a_xtal_valid: assert property ((extSettled3 && extGroup == EXT_GRP_XTAL) |-> crystalValidFlag)
        else $error("crystal valid flag missed a settled crystal");
    a_xtal_unused: assert property ((extGroup != EXT_GRP_XTAL) |-> !crystalValidFlag)
        else $error("crystal valid while crystal unused");
    a_rc_ready: assert property ((extGroup == EXT_GRP_RC) [*2] |-> extOscReady)
        else $error("rc mode not ready at once");
    a_rdy_read: assert property (sfrReq.rdEn && sfrReq.addr == INT_OSC_CTRL_ADDR
        |=> sfrRdData[INT_RDY_BIT] == $past(intOscEnable && intRdySync2))
        else $error("ready flag read wrong");
endmodule

//--- test/system_clock_select_tb.sv
// self-checking bench for the system clock source controller
`timescale 1ns/1ps
module system_clock_select_tb;
    import osc_ctrl_pkg::*;
    // ============================================================
    // stimulus, observed outputs and bench counters
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    sfr_req_s sfrReq = '0;
    logic intOscTick = 1'b0;
    logic extOscTick = 1'b0;
    logic intOscAtFreq = 1'b1; // analog at-frequency level
    logic extOscSettled = 1'b0; // analog settled level
    logic [7:0] sfrRdData;
    osc_drive_s oscDrive;
    logic sysClkTick, periphExtTick, sysclkIsExternal, extOscReady;
    int mismatches = 0;
    int testsRun = 0;
    int cycles = 0;
    int sysCnt = 0; // system ticks seen
    int periCnt = 0; // peripheral ticks seen
    int mInt, mExt, mSrc; // model register images
    logic [31:0] rnd;

    // 250 MHz clock
    always #2 clk = ~clk;

    system_clock_select system_clock_select_inst (
        .clk(clk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
        .intOscTick(intOscTick), .extOscTick(extOscTick), .intOscAtFreq(intOscAtFreq),
        .extOscSettled(extOscSettled), .oscDrive(oscDrive), .sysClkTick(sysClkTick),
        .periphExtTick(periphExtTick), .sysclkIsExternal(sysclkIsExternal), .extOscReady(extOscReady));

    // ============================================================
    // pulse counting and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (sysClkTick === 1'b1) sysCnt <= sysCnt + 1;
        if (periphExtTick === 1'b1) periCnt <= periCnt + 1;
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            finish_test();
        end
    end

    // ============================================================
    // model and compare tasks
    // expected read image from the model registers and analog levels
    function automatic logic [7:0] expRead(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == INT_OSC_CTRL_ADDR) v = mInt[7:0] | {1'b0, mInt[7] & intOscAtFreq, 6'h00};
        if (a == EXT_OSC_CTRL_ADDR) v = mExt[7:0] | {mExt[6:5] == 2'h3 && extOscSettled, 7'h00};
        if (a == CLK_SRC_ADDR) v = mSrc[7:0];
        return v;
    endfunction

    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic checkFlag(input logic got, input logic exp, input string what);
        checkByte({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic checkCount(input int got, input int exp, input string what);
        testsRun++;
        if (got != exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // ============================================================
    // bus and tick drivers
    // one-cycle write strobe, model follows the writable bits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrReq <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
        @(posedge clk);
        sfrReq.wrEn <= 1'b0;
        if (a == INT_OSC_CTRL_ADDR) mInt = int'(d & 8'h83);
        if (a == EXT_OSC_CTRL_ADDR) mExt = int'(d & 8'h77);
        if (a == CLK_SRC_ADDR) mSrc = int'(d & 8'h01);
        #1;
    endtask

    // one-cycle read strobe, data compared once registered
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sfrReq <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
        @(posedge clk);
        sfrReq.rdEn <= 1'b0;
        #1 checkByte(sfrRdData, expRead(a), "register read");
    endtask

    // let registered outputs and synchronisers land
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    // back-to-back oscillator ticks, counters cleared first
    task automatic pulse(input logic useExt, input int n);
        @(posedge clk);
        #1 sysCnt = 0;
        periCnt = 0;
        repeat (n) begin
            @(posedge clk);
            intOscTick <= ~useExt;
            extOscTick <= useExt;
        end
        @(posedge clk);
        intOscTick <= 1'b0;
        extOscTick <= 1'b0;
        settle();
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ============================================================
    // main sequence
    initial begin
        rnd = $urandom(32'h060d9097);
        mInt = 8'h80;
        mExt = 0;
        mSrc = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        checkFlag(sysclkIsExternal, 1'b0, "source after reset");
        checkFlag(oscDrive.intOscEnable, 1'b1, "enable after reset");
        rd(INT_OSC_CTRL_ADDR);
        rd(8'h55);
        intOscAtFreq <= 1'b0;
        settle();
        wr(INT_OSC_CTRL_ADDR, 8'hff);
        rd(INT_OSC_CTRL_ADDR);
        intOscAtFreq <= 1'b1;
        settle();
        // every divide code, from a stopped and cleared divider
        for (int s = 0; s < 4; s++) begin
            wr(INT_OSC_CTRL_ADDR, 8'h00);
            checkFlag(oscDrive.intOscEnable, 1'b0, "oscillator stopped");
            pulse(1'b0, 8);
            checkCount(sysCnt, 0, "ticks while stopped");
            wr(INT_OSC_CTRL_ADDR, 8'h80 | 8'(s));
            rd(INT_OSC_CTRL_ADDR);
            pulse(1'b0, 16);
            checkCount(sysCnt, 16 >> (3 - s), "divided ticks");
        end
        // cmos source selected on the fly and back again
        wr(EXT_OSC_CTRL_ADDR, 8'h20);
        settle();
        checkFlag(extOscReady, 1'b1, "cmos usable at once");
        wr(CLK_SRC_ADDR, 8'h01);
        settle();
        checkFlag(sysclkIsExternal, 1'b1, "switched to external");
        pulse(1'b1, 5);
        checkCount(sysCnt, 5, "external system ticks");
        pulse(1'b0, 8);
        checkCount(sysCnt, 0, "internal ignored while external");
        wr(CLK_SRC_ADDR, 8'h00);
        settle();
        checkFlag(sysclkIsExternal, 1'b0, "switched back");
        pulse(1'b1, 5);
        checkCount(sysCnt, 0, "external off system clock");
        checkCount(periCnt, 5, "external kept for peripherals");
        // crystal valid only once settled, reserved bit ignored
        wr(EXT_OSC_CTRL_ADDR, 8'h6f);
        rd(EXT_OSC_CTRL_ADDR);
        checkFlag(extOscReady, 1'b0, "crystal not yet valid");
        extOscSettled <= 1'b1;
        settle();
        rd(EXT_OSC_CTRL_ADDR);
        checkFlag(extOscReady, 1'b1, "crystal valid");
        wr(EXT_OSC_CTRL_ADDR, 8'h40);
        settle();
        rd(EXT_OSC_CTRL_ADDR);
        checkFlag(extOscReady, 1'b1, "rc usable at once");
        // random external settings reach the oscillator drive
        repeat (4) begin
            rnd = $urandom;
            wr(EXT_OSC_CTRL_ADDR, rnd[7:0]);
            checkByte({1'b0, oscDrive}, {1'b0, mInt[7], mExt[6:4], mExt[2:0]}, "oscillator drive");
            rd(EXT_OSC_CTRL_ADDR);
        end
        // reset in mid-run while external is selected
        wr(EXT_OSC_CTRL_ADDR, 8'h20);
        wr(CLK_SRC_ADDR, 8'h01);
        settle();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        mInt = 8'h80;
        mExt = 0;
        mSrc = 0;
        settle();
        checkFlag(sysclkIsExternal, 1'b0, "source after second reset");
        rd(CLK_SRC_ADDR);
        rd(INT_OSC_CTRL_ADDR);
        checkByte({1'b0, oscDrive}, 8'h40, "drive after second reset");
        pulse(1'b1, 3);
        checkCount(periCnt, 0, "external off, peripherals quiet");
        checkCount(sysCnt, 0, "external ticks off system clock");
        finish_test();
    end
endmodule
